//--- src/isa_slave_local_sram_access.sv
// Purpose: ISA slave access to local SRAM and boot PROM
// Assumes: Host strobes and pins are asynchronous; eep_* are on clk
// Notes:   Host cycles stretched by the open-drain ready pin
// Function
// - Master or slave mode comes only from a strap pin
// - Slave architecture bit 13 selects shared memory or programmed I/O
// - 24-byte I/O window at one of 16 bases
// - Master mode decodes the boot PROM with on-chip comparators
// - Location registers load from EEPROM before decoding starts
// - Slave mode keeps data structures in local SRAM it controls
// - PROM match selects PROM; two byte reads form one word
// - Shared memory match selects SRAM; device runs the SRAM cycle
// - Shared memory word cycles split or join into byte cycles
// - PROM and SRAM both answer as 16-bit memory
// - Programmed I/O reaches SRAM through address and data ports only
// - Programmed I/O data port word accesses become byte cycles
// - Prefetch speculates the next ascending SRAM word
// - Valid prefetch is returned with no wait states
// - Invalid prefetch stretches the cycle until the word is read
// - Plug and Play: active at reset only for network boot
// - PC card mode maps buffer to memory or reaches it by I/O
// - PC card common memory with match low goes to SRAM
`timescale 1ns/1ps
module isa_slave_local_sram_access
  import isa_sram_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        strap_master,
  input  wire logic        strap_net_boot,
  input  wire logic        strap_pnp,
  input  wire logic        strap_pcmcia,
  input  wire logic        eeprom_present,
  input  wire logic        eep_valid,
  input  wire logic [3:0]  eep_io_idx,
  input  wire logic [10:0] eep_prom_base,
  input  wire logic [1:0]  eep_prom_size,
  input  wire logic        eep_arch,
  input  wire logic        pnp_activate,
  input  wire logic        ior_n,
  input  wire logic        iow_n,
  input  wire logic        memr_n,
  input  wire logic        memw_n,
  input  wire logic        sbhe_n,
  input  wire logic [23:0] sa,
  input  wire logic [15:0] sd_in,
  input  wire logic        boot_rom_match_in_n,
  input  wire logic        shared_ram_match_in_n,
  input  wire logic [7:0]  mem_rdata,
  output logic [15:0]      sd_out,
  output logic             sd_oe,
  output logic             iochrdy_out,
  output logic             iochrdy_oe,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic             mem_data_oe,
  output logic             sram_cs_n,
  output logic             prom_cs_n,
  output logic             mem_oe_n,
  output logic             mem_we_n,
  output logic             mode_master,
  output logic             slave_arch_select,
  output logic             dev_active
);
  typedef enum logic [1:0] {C_WAIT, C_LOAD, C_RUN} cst_t;
  typedef enum logic [1:0] {H_IDLE, H_FETCH, H_HOLD, H_PREF} hst_t;
  localparam int          SW = 60;
  localparam logic [SW-1:0] SYNC_RST = {7'h7f, 53'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [SW-1:0] s_vec;
  pin_sync #(.W(SW), .RST(SYNC_RST)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({ior_n, iow_n, memr_n, memw_n, sbhe_n, boot_rom_match_in_n,
              shared_ram_match_in_n, strap_master, strap_net_boot, strap_pnp,
              strap_pcmcia, eeprom_present, sa, sd_in, mem_rdata}),
    .q      (s_vec)
  );
  wire        s_ior_n   = s_vec[59];
  wire        s_iow_n   = s_vec[58];
  wire        s_memr_n  = s_vec[57];
  wire        s_memw_n  = s_vec[56];
  wire        s_sbhe_n  = s_vec[55];
  wire        s_boot_rom_match_in_n  = s_vec[54];
  wire        s_shared_ram_match_in_n  = s_vec[53];
  wire        s_master  = s_vec[52];
  wire        s_netboot = s_vec[51];
  wire        s_pnp     = s_vec[50];
  wire        s_pcm     = s_vec[49];
  wire        s_eep     = s_vec[48];
  wire [23:0] s_sa      = s_vec[47:24];
  wire [15:0] s_sd      = s_vec[23:8];
  wire [7:0]  s_mrd     = s_vec[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration state
  cst_t        cst_ff;
  logic [1:0]  ccnt_ff;
  logic        master_ff, pcm_ff, active_ff;
  logic [3:0]  io_idx_ff;
  logic [10:0] prom_base_ff;
  logic [1:0]  prom_sz_ff;
  logic [15:0] misc_b_ff;
  logic [6:0]  rap_ff;
  logic [15:0] ptr_ff;
  wire         run = (cst_ff == C_RUN);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cst_ff <= C_WAIT; ccnt_ff <= '0; master_ff <= 1'b0; pcm_ff <= 1'b0;
      active_ff <= 1'b0;
    end else begin
      unique case (cst_ff)
        C_WAIT: begin
          ccnt_ff <= ccnt_ff + 2'h1;
          if (ccnt_ff == 2'(SYNC_STAGES)) begin
            master_ff <= s_master;
            pcm_ff    <= s_pcm;
            cst_ff    <= C_LOAD;
          end
        end
        C_LOAD: begin
          if (!s_eep || eep_valid) begin
            cst_ff    <= C_RUN;
            active_ff <= !s_pnp || s_netboot;
          end
        end
        C_RUN: begin
          if (pnp_activate) active_ff <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire        io_cyc   = !s_ior_n || !s_iow_n;
  wire        mem_cyc  = !s_memr_n || !s_memw_n;
  wire        cmd_rd   = !s_ior_n || !s_memr_n;
  wire        cmd_wr   = !s_iow_n || !s_memw_n;
  wire        any_cmd  = cmd_rd || cmd_wr;
  wire        slave    = !master_ff;
  wire        pio      = misc_b_ff[ARCH_BIT];
  wire [9:0]  io_base  = IO_BASE0 + IO_STEP * 10'(io_idx_ff);
  wire [9:0]  io_off   = s_sa[9:0] - io_base;
  wire        io_hit   = io_cyc && s_sa[15:10] == '0 && io_off < WIN_BYTES;
  wire        idp_hit  = io_hit && io_off == OFS_IDP;
  wire        rap_hit  = io_hit && io_off == OFS_RAP;
  wire [10:0] blk_mask = PROM_BLK_ALL << prom_sz_ff;
  wire        cmp_hit  = ((s_sa[23:PROM_LSB] ^ prom_base_ff) & blk_mask) == '0;
  wire        prom_sel = master_ff ? cmp_hit : (pcm_ff ? s_shared_ram_match_in_n : !s_boot_rom_match_in_n);
  wire        prom_hit = !s_memr_n && prom_sel;
  wire        sram_mem = slave && !pio && mem_cyc && !s_shared_ram_match_in_n;
  wire        port_a   = idp_hit && rap_ff == IDX_PORT_A && slave && pio;
  wire        sram_hit = sram_mem || port_a;
  wire        claim    = run && active_ff && any_cmd && (io_hit || prom_hit || sram_mem);
  wire        is16     = !s_sbhe_n && !s_sa[0];
  wire [15:0] acc_addr = sram_mem ? s_sa[15:0] : ptr_ff;
  wire [15:0] acc_algn = {acc_addr[15:1], 1'b0};
  wire [15:0] prm_algn = {s_sa[15:1], 1'b0};
  wire [15:0] acc_step = is16 ? WORD_STEP : BYTE_STEP;
  wire [15:0] wr_data  = is16 ? s_sd : {8'h00, acc_addr[0] ? s_sd[15:8] : s_sd[7:0]};
  wire        odd_rd   = !is16 && s_sa[0];

  ////////////////////////////////////////////////////////////////////////////
  // Host cycle engine with prefetch
  hst_t        hst_ff;
  logic        pf_valid_ff, pf_next_ff, srd_ff, odd_ff, wait_ff;
  logic [15:0] pf_addr_ff, pf_data_ff;
  logic [15:0] reg_rd;
  byte_xfer_if x ();
  wire         pf_hit = pf_valid_ff && pf_addr_ff == acc_algn;

  always_comb begin
    reg_rd = '0;
    if (rap_hit) reg_rd = {9'h000, rap_ff};
    else if (idp_hit && rap_ff == IDX_PORT_B) reg_rd = ptr_ff;
    else if (idp_hit && rap_ff == IDX_MISC_B) reg_rd = misc_b_ff;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hst_ff <= H_IDLE; pf_valid_ff <= 1'b0; pf_next_ff <= 1'b0; srd_ff <= 1'b0;
      odd_ff <= 1'b0; wait_ff <= 1'b0; pf_addr_ff <= '0; pf_data_ff <= '0;
      sd_out <= '0; sd_oe <= 1'b0; rap_ff <= '0; ptr_ff <= '0;
      misc_b_ff <= MISC_B_RST; io_idx_ff <= DEF_IO_IDX;
      prom_base_ff <= DEF_PROM_BAS; prom_sz_ff <= DEF_PROM_SZ;
      x.req <= 1'b0; x.wr <= 1'b0; x.prom <= 1'b0; x.word <= 1'b0;
      x.addr <= '0; x.wdata <= '0;
    end else begin
      x.req <= 1'b0;
      if (cst_ff == C_LOAD && s_eep && eep_valid) begin
        io_idx_ff <= eep_io_idx; prom_base_ff <= eep_prom_base;
        prom_sz_ff <= eep_prom_size; misc_b_ff[ARCH_BIT] <= eep_arch;
      end
      unique case (hst_ff)
        H_IDLE: begin
          wait_ff <= 1'b0;
          if (claim && sram_hit && cmd_rd && pf_hit) begin
            sd_out <= odd_rd ? {2{pf_data_ff[15:8]}} : pf_data_ff;
            sd_oe <= 1'b1; pf_valid_ff <= 1'b0; pf_next_ff <= 1'b1;
            pf_addr_ff <= acc_algn + WORD_STEP;
            if (port_a) ptr_ff <= ptr_ff + acc_step;
            hst_ff <= H_HOLD;
          end else if (claim && (sram_hit || prom_hit)) begin
            x.req <= 1'b1; x.wr <= cmd_wr && sram_hit; x.prom <= !sram_hit;
            x.word <= cmd_rd || is16;
            x.addr <= sram_hit ? (cmd_rd ? acc_algn : acc_addr) : prm_algn;
            x.wdata <= wr_data;
            srd_ff <= sram_hit && cmd_rd; odd_ff <= odd_rd;
            pf_valid_ff <= 1'b0;
            if (sram_hit && cmd_rd) pf_addr_ff <= acc_algn + WORD_STEP;
            if (port_a) ptr_ff <= ptr_ff + acc_step;
            wait_ff <= 1'b1; hst_ff <= H_FETCH;
          end else if (claim) begin
            if (cmd_wr && rap_hit) rap_ff <= s_sd[6:0];
            if (cmd_wr && idp_hit && rap_ff == IDX_PORT_B) begin
              ptr_ff <= s_sd; pf_valid_ff <= 1'b0;
            end
            if (cmd_wr && idp_hit && rap_ff == IDX_MISC_B) misc_b_ff <= s_sd;
            sd_out <= reg_rd; sd_oe <= cmd_rd;
            hst_ff <= H_HOLD;
          end
        end
        H_FETCH: begin
          if (x.done) begin
            sd_out <= odd_ff ? {2{x.rdata[15:8]}} : x.rdata;
            sd_oe <= !x.wr; pf_next_ff <= srd_ff; wait_ff <= 1'b0;
            hst_ff <= H_HOLD;
          end
        end
        H_HOLD: begin
          if (!any_cmd) begin
            sd_oe <= 1'b0; pf_next_ff <= 1'b0;
            if (pf_next_ff) begin
              x.req <= 1'b1; x.wr <= 1'b0; x.prom <= 1'b0; x.word <= 1'b1;
              x.addr <= pf_addr_ff; hst_ff <= H_PREF;
            end else begin
              hst_ff <= H_IDLE;
            end
          end
        end
        H_PREF: begin
          wait_ff <= claim;
          if (x.done) begin
            pf_data_ff <= x.rdata; pf_valid_ff <= 1'b1; hst_ff <= H_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local memory cycles
  byte_engine u_eng (
    .clk         (clk),
    .arst_n      (arst_n),
    .bus         (x.slave),
    .mem_rdata   (s_mrd),
    .mem_addr    (mem_addr),
    .mem_wdata   (mem_wdata),
    .mem_data_oe (mem_data_oe),
    .sram_cs_n   (sram_cs_n),
    .prom_cs_n   (prom_cs_n),
    .mem_oe_n    (mem_oe_n),
    .mem_we_n    (mem_we_n)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      iochrdy_out <= 1'b0; iochrdy_oe <= 1'b0; mode_master <= 1'b0;
      slave_arch_select <= 1'b0; dev_active <= 1'b0;
    end else begin
      iochrdy_oe <= wait_ff;
      mode_master <= master_ff;
      slave_arch_select <= pio;
      dev_active <= active_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_miss_start;
    hst_ff == H_IDLE && claim && sram_hit && cmd_rd && !pf_hit;
  endsequence
  sequence s_fetch_wait;
    hst_ff == H_FETCH && wait_ff;
  endsequence
  sequence s_rdy_drop;
    !wait_ff ##1 !iochrdy_oe;
  endsequence

  a_strap_only: assert property (run |=> $stable(master_ff))
    else $error("Operating mode changed after configuration");
  a_pio_no_mem: assert property (run && slave && pio |-> !sram_mem)
    else $error("Shared memory decoded in programmed I/O mode");
  a_io_window: assert property (io_hit |-> s_sa[9:0] >= io_base
    && s_sa[9:0] <= io_base + (WIN_BYTES - 10'h001))
    else $error("I/O claim outside the window");
  a_prom_cmp: assert property (master_ff && prom_hit |-> cmp_hit)
    else $error("PROM decode without comparator match");
  a_no_early: assert property (!run |-> !claim && hst_ff == H_IDLE)
    else $error("Bus decode before configuration load");
  a_hit_fast: assert property (hst_ff == H_IDLE && claim && sram_hit && cmd_rd && pf_hit
    |=> hst_ff == H_HOLD && !wait_ff && sd_oe)
    else $error("Prefetch hit inserted wait states");
  a_miss_wait: assert property (s_miss_start |=> s_fetch_wait ##1 iochrdy_oe)
    else $error("Prefetch miss did not stretch the cycle");
  a_pf_next: assert property (s_miss_start
    |=> pf_addr_ff == $past(acc_algn) + WORD_STEP)
    else $error("Speculated address not next ascending word");
  a_wr_inval: assert property (hst_ff == H_IDLE && claim && sram_hit && cmd_wr
    |=> !pf_valid_ff)
    else $error("SRAM write left prefetch valid");
  a_pnp_act: assert property (cst_ff == C_LOAD ##1 run && !$past(pnp_activate)
    |-> active_ff == (!s_pnp || s_netboot) || $past(run))
    else $error("Plug and Play reset activity wrong");
  a_ptr_inval: assert property (hst_ff == H_IDLE && claim && cmd_wr && idp_hit
    && rap_ff == IDX_PORT_B |=> !pf_valid_ff)
    else $error("Pointer reload left prefetch valid");
  a_pio_word: assert property (hst_ff == H_IDLE && claim && port_a && is16
    && !(cmd_rd && pf_hit) |=> x.req && x.word)
    else $error("Data port word access not split into bytes");
  a_shm_word: assert property (hst_ff == H_IDLE && claim && sram_mem && is16
    && !(cmd_rd && pf_hit) |=> x.req && x.word && !x.prom)
    else $error("Shared memory word access not split into bytes");
  a_prom_word: assert property (hst_ff == H_IDLE && claim && prom_hit && !sram_hit
    |=> x.req && x.prom && x.word && !x.wr)
    else $error("Boot PROM read not assembled from two bytes");
  a_rdy_release: assert property (hst_ff == H_FETCH && x.done |=> s_rdy_drop)
    else $error("Ready not released after data fetched");
  a_pf_request: assert property (hst_ff == H_HOLD && !any_cmd && pf_next_ff
    |=> x.req && !x.wr && x.word && x.addr == $past(pf_addr_ff))
    else $error("Prefetch not started at speculated address");
endmodule // isa_slave_local_sram_access

//--- src/isa_sram_pkg.sv
// Purpose: Shared constants for the ISA slave local SRAM access block
// Assumes: 250 MHz core clock, 16-bit host bus, byte-wide local memory
// Notes:   Timing counts derive from times given in ns
package isa_sram_pkg;
  localparam int          CLK_MHZ      = 250;
  localparam int          MEM_ACC_NS   = 20;
  localparam int          MEM_ACC_CYC  = (MEM_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int          SYNC_STAGES  = 2;
  localparam int          BYTE_LAST    = MEM_ACC_CYC + SYNC_STAGES;
  localparam logic [9:0]  IO_BASE0     = 10'h200;
  localparam logic [9:0]  IO_STEP      = 10'h020;
  localparam logic [9:0]  WIN_BYTES    = 10'h018;
  localparam logic [9:0]  OFS_IDP      = 10'h010;
  localparam logic [9:0]  OFS_RAP      = 10'h012;
  localparam logic [6:0]  IDX_PORT_A   = 7'h00;
  localparam logic [6:0]  IDX_PORT_B   = 7'h01;
  localparam logic [6:0]  IDX_MISC_B   = 7'h02;
  localparam int          ARCH_BIT     = 13;
  localparam logic [15:0] MISC_B_RST   = 16'h0000;
  localparam logic [15:0] WORD_STEP    = 16'h0002;
  localparam logic [15:0] BYTE_STEP    = 16'h0001;
  localparam int          PROM_LSB     = 13;
  localparam logic [10:0] PROM_BLK_ALL = 11'h7ff;
  localparam logic [3:0]  DEF_IO_IDX   = 4'h0;
  localparam logic [10:0] DEF_PROM_BAS = 11'h060;
  localparam logic [1:0]  DEF_PROM_SZ  = 2'h0;
endpackage

//--- src/byte_xfer_if.sv
// Purpose: Word request path between host logic and the byte engine
// Assumes: req is a one-cycle pulse, done a one-cycle pulse
// Notes:   word=1 runs two byte cycles, low byte first
`timescale 1ns/1ps
interface byte_xfer_if;
  logic        req;
  logic        wr;
  logic        prom;
  logic        word;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        done;
  modport master (output req, wr, prom, word, addr, wdata, input rdata, done);
  modport slave  (input req, wr, prom, word, addr, wdata, output rdata, done);
endinterface

//--- src/byte_engine.sv
// Purpose: Runs one or two byte cycles on the local SRAM or boot PROM
// Assumes: mem_rdata already synchronised
// Notes:   Strobes active BYTE_LAST cycles, then one idle cycle
`timescale 1ns/1ps
module byte_engine
  import isa_sram_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  byte_xfer_if.slave      bus,
  input  wire logic [7:0] mem_rdata,
  output logic [15:0]     mem_addr,
  output logic [7:0]      mem_wdata,
  output logic            mem_data_oe,
  output logic            sram_cs_n,
  output logic            prom_cs_n,
  output logic            mem_oe_n,
  output logic            mem_we_n
);
  typedef enum logic [1:0] {E_IDLE, E_LO, E_HI} est_t;
  localparam int WORD_CYC = 2 * (BYTE_LAST + 1) + 1;
  est_t        st_ff;
  logic [3:0]  cnt_ff;
  logic        wr_ff, prom_ff, word_ff;
  logic [15:0] wd_ff;
  wire         last = (cnt_ff == 4'(BYTE_LAST));
  wire         drop = (cnt_ff == 4'(BYTE_LAST - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= E_IDLE; cnt_ff <= '0; wr_ff <= 1'b0; prom_ff <= 1'b0;
      word_ff <= 1'b0; wd_ff <= '0; bus.done <= 1'b0; bus.rdata <= '0;
      mem_addr <= '0; mem_wdata <= '0; mem_data_oe <= 1'b0;
      sram_cs_n <= 1'b1; prom_cs_n <= 1'b1; mem_oe_n <= 1'b1; mem_we_n <= 1'b1;
    end else begin
      bus.done <= 1'b0;
      if (st_ff == E_IDLE) begin
        if (bus.req) begin
          st_ff <= E_LO; cnt_ff <= '0; wr_ff <= bus.wr; prom_ff <= bus.prom;
          word_ff <= bus.word; wd_ff <= bus.wdata;
          mem_addr <= bus.addr; mem_wdata <= bus.wdata[7:0];
          mem_data_oe <= bus.wr; mem_we_n <= !bus.wr; mem_oe_n <= bus.wr;
          sram_cs_n <= bus.prom; prom_cs_n <= !bus.prom;
        end
      end else if (drop) begin
        cnt_ff <= cnt_ff + 4'h1;
        if (st_ff == E_LO) bus.rdata[7:0] <= mem_rdata;
        else bus.rdata[15:8] <= mem_rdata;
        sram_cs_n <= 1'b1; prom_cs_n <= 1'b1; mem_oe_n <= 1'b1;
        mem_we_n <= 1'b1; mem_data_oe <= 1'b0;
      end else if (last) begin
        cnt_ff <= '0;
        if (st_ff == E_LO && word_ff) begin
          st_ff <= E_HI; mem_addr[0] <= 1'b1; mem_wdata <= wd_ff[15:8];
          mem_data_oe <= wr_ff; mem_we_n <= !wr_ff; mem_oe_n <= wr_ff;
          sram_cs_n <= prom_ff; prom_cs_n <= !prom_ff;
        end else begin
          st_ff <= E_IDLE; bus.done <= 1'b1;
        end
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end

  a_word_two_bytes: assert property (@(posedge clk) disable iff (!arst_n)
    (bus.req && bus.word && st_ff == E_IDLE) |-> ##WORD_CYC bus.done)
    else $error("Word transfer did not finish after two byte cycles");
  a_prom_no_sram: assert property (@(posedge clk) disable iff (!arst_n)
    !prom_cs_n |-> sram_cs_n && mem_we_n)
    else $error("Boot PROM cycle touched SRAM or write strobe");
endmodule // byte_engine

//--- src/pin_sync.sv
// Purpose: Two-flop synchroniser for a bundle of asynchronous pins
// Assumes: Each bit is an independent level
// Notes:   Reset value per bit keeps idle strobes inactive
`timescale 1ns/1ps
module pin_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  logic [W-1:0] meta_ff;
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        meta_ff[i] <= RST[i];
        q[i]       <= RST[i];
      end else begin
        meta_ff[i] <= d[i];
        q[i]       <= meta_ff[i];
      end
    end
  end
endmodule // pin_sync

//--- tb/mem_decode_model.sv
// Purpose: Local SRAM, boot PROM and host address decode beside the block
// Assumes: Read data is taken while mem_oe_n is low
// Notes:   Unselected data lines show the inverse of the last value
`timescale 1ns/1ps
module mem_decode_model (
  input  wire logic        clk,
  input  wire logic [23:0] sa,
  input  wire logic        pio,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        sram_cs_n,
  input  wire logic        prom_cs_n,
  input  wire logic        mem_oe_n,
  input  wire logic        mem_we_n,
  input  wire logic        data_oe,
  output logic             rom_hit_n,
  output logic             ram_hit_n,
  output logic [7:0]       rdata
);
  logic [7:0] ram [0:65535];
  logic [7:0] last = 8'h00;
  wire        ram_rd = !mem_oe_n && !sram_cs_n;
  wire        rom_rd = !mem_oe_n && !prom_cs_n;
  assign rom_hit_n = !(sa[23:13] == 11'h060);
  assign ram_hit_n = pio || !(sa[23:16] == 8'h0d);
  assign rdata = ram_rd ? ram[mem_addr] : rom_rd ? (mem_addr[7:0] ^ 8'h3c) : ~last;
  always_ff @(posedge clk) begin
    last <= rdata;
    if (!sram_cs_n && !mem_we_n && data_oe) begin
      ram[mem_addr] <= mem_wdata;
    end
  end
endmodule // mem_decode_model

//--- tb/isa_slave_local_sram_access_test.sv
// Purpose: Self-checking bench for ISA slave access to local memory
// Assumes: Host strobes driven at the falling edge
// Notes:   Cycles are spaced so no prefetch is running at a new strobe
`timescale 1ns/1ps
module isa_slave_local_sram_access_test;
  import isa_sram_pkg::*;
  logic        clk, arst_n, eep_pres, eep_valid, eep_arch, pnp, pnp_act;
  logic        ior_n, iow_n, memr_n, memw_n, rom_n, ram_n, sd_oe, rdy_oe;
  logic        sram_cs_n, prom_cs_n, mem_oe_n, mem_we_n, master, arch, active, w;
  logic        nb, rdy_out, doe;
  logic [3:0]  io_idx;
  logic [23:0] sa, base;
  logic [15:0] sd_in, sd_out, mem_addr, q;
  logic [7:0]  mem_rdata, mem_wdata;
  int          errors, num_checks;
  isa_slave_local_sram_access i_isa_slave_local_sram_access (.clk(clk), .arst_n(arst_n),
    .strap_master(1'b0), .strap_net_boot(nb), .strap_pnp(pnp), .strap_pcmcia(1'b0),
    .eeprom_present(eep_pres), .eep_valid(eep_valid), .eep_io_idx(io_idx),
    .eep_prom_base(11'h060), .eep_prom_size(2'h0), .eep_arch(eep_arch),
    .pnp_activate(pnp_act), .ior_n(ior_n), .iow_n(iow_n), .memr_n(memr_n), .memw_n(memw_n),
    .sbhe_n(1'b0), .sa(sa), .sd_in(sd_in), .boot_rom_match_in_n(rom_n),
    .shared_ram_match_in_n(ram_n), .mem_rdata(mem_rdata), .sd_out(sd_out), .sd_oe(sd_oe),
    .iochrdy_out(rdy_out), .iochrdy_oe(rdy_oe), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_data_oe(doe), .sram_cs_n(sram_cs_n), .prom_cs_n(prom_cs_n), .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n), .mode_master(master), .slave_arch_select(arch), .dev_active(active));
  mem_decode_model i_mem_decode_model (.clk(clk), .sa(sa), .pio(arch), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .sram_cs_n(sram_cs_n), .prom_cs_n(prom_cs_n),
    .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .rom_hit_n(rom_n), .ram_hit_n(ram_n),
    .data_oe(doe), .rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check16({15'h0000, got}, {15'h0000, exp});
  endtask
  // Kind 0 io read, 1 io write, 2 mem read, 3 mem write
  task automatic host(input int k, input logic [23:0] a, input logic [15:0] d, input bit quiet);
    int n;
    w = 1'b0;
    @(negedge clk);
    sa = a;
    sd_in = d;
    {ior_n, iow_n, memr_n, memw_n} = ~(4'h8 >> k);
    for (n = 0; n < 60; n++) begin
      @(negedge clk);
      if (rdy_oe === 1'b1) w = 1'b1;
      if (quiet && n == 20) break;
      if (!quiet && rdy_oe === 1'b0 && (k[0] ? n > 8 : sd_oe === 1'b1)) break;
    end
    q = sd_out;
    if (w) check1(rdy_out, 1'b0);
    if (n == 60) begin
      errors++;
      results();
    end
    if (quiet) check1(sd_oe, 1'b0);
    @(negedge clk);
    {ior_n, iow_n, memr_n, memw_n} = 4'hf;
    repeat (24) @(negedge clk);
  endtask
  task automatic pio_w(input logic [6:0] idx, input logic [15:0] v);
    host(1, base + 24'h12, {9'h000, idx}, 0);
    host(1, base + 24'h10, v, 0);
  endtask
  task automatic pio_r(input logic [15:0] exp, input logic wt);
    host(1, base + 24'h12, {9'h000, IDX_PORT_A}, 0);
    host(0, base + 24'h10, 16'h0000, 0);
    check16(q, exp);
    check1(w, wt);
  endtask
  task automatic do_reset;
    arst_n = 1'b0;
    repeat (4) @(negedge clk);
    check1(sram_cs_n, 1'b1);
    check1(sd_oe, 1'b0);
    arst_n = 1'b1;
    repeat (12) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_shared;
    check1(master, 1'b0);
    check1(arch, 1'b0);
    check1(active, 1'b1);
    host(3, 24'h0d0040, 16'hcafe, 0);
    host(3, 24'h0d0042, 16'h0bad, 0);
    host(2, 24'h0d0040, 16'h0000, 0);
    check16(q, 16'hcafe);
    check1(w, 1'b1);
    host(2, 24'h0d0042, 16'h0000, 0);
    check16(q, 16'h0bad);
    check1(w, 1'b0);
    host(2, 24'h0c0004, 16'h0000, 0);
    check16(q, {8'h05 ^ 8'h3c, 8'h04 ^ 8'h3c});
    $display("test shared done");
  endtask
  task automatic t_pio;
    pio_w(IDX_MISC_B, 16'h2000);
    check1(arch, 1'b1);
    host(2, 24'h0d0040, 16'h0000, 1);
    pio_w(IDX_PORT_B, 16'h0020);
    pio_w(IDX_PORT_A, 16'h1234);
    host(1, base + 24'h10, 16'h5678, 0);
    host(1, base + 24'h10, 16'h9abc, 0);
    pio_w(IDX_PORT_B, 16'h0020);
    pio_r(16'h1234, 1'b1);
    pio_r(16'h5678, 1'b0);
    pio_w(IDX_PORT_B, 16'h0024);
    pio_r(16'h9abc, 1'b1);
    $display("test pio done");
  endtask
  task automatic t_eeprom;
    eep_pres = 1'b1;
    eep_valid = 1'b1;
    eep_arch = 1'b1;
    io_idx = 4'h1;
    pnp = 1'b1;
    do_reset();
    check1(arch, 1'b1);
    check1(active, 1'b0);
    pnp_act = 1'b1;
    @(negedge clk);
    pnp_act = 1'b0;
    repeat (4) @(negedge clk);
    check1(active, 1'b1);
    base = 24'h000220;
    pio_w(IDX_PORT_B, 16'h0020);
    pio_r(16'h1234, 1'b1);
    host(0, 24'h000210, 16'h0000, 1);
    nb = 1'b1;
    do_reset();
    check1(active, 1'b1);
    $display("test eeprom done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {eep_pres, eep_valid, eep_arch, pnp, pnp_act, nb} = 6'h00;
    {ior_n, iow_n, memr_n, memw_n} = 4'hf;
    io_idx = 4'h0;
    sa = 24'h000000;
    sd_in = 16'h0000;
    base = 24'h000200;
    errors = 0;
    num_checks = 0;
    do_reset();
    t_shared();
    t_pio();
    t_eeprom();
    results();
  end
endmodule // isa_slave_local_sram_access_test
